// file: csr_slice_pkg.sv
// constants and types of the control/status register slice
// Function
// R1: descriptor-unavailable enable with normal summary raises interrupt
// R2: tx-stopped enable with abnormal summary raises interrupt
// R3: tx-done enable with normal summary; enables reset zero
// R4: count dropped frames when no receive descriptor
// R5: reading dropped count returns value then clears
// R6: overflow flag sets on wrap, clears on read
// R7: eeprom read allowed only with select bit
// R8: eeprom write allowed only with select bit
// R9: status bit shows eeprom serial output, default one
// R10: written data bit drives eeprom data input
// R11: written clock bit drives eeprom clock pin
// R12: chip-select bit drives eeprom select, default one
// R13: timer counts down every 204 microseconds
// R14: continuous bit selects repeating timer, resets zero
// R15: crc seed zero or all ones by type bit
// R16: five pattern match enables gate wake frames
// R17: link-down detect enable sets link change flag
// R18: link-up detect enable sets link change flag
// R19: wake frame enable makes matched frame power event
// R20: normal summary gates all normal interrupt sources
// R21: abnormal summary gates all abnormal interrupt sources
// R22: link change flag write-one clear, power-up reset only
// R23: timer expiry flags event, reloads if continuous
// R24: eeprom pins follow register only while selected
package csr_slice_pkg;
    // ****************************************
    // register byte offsets
    // ****************************************
    localparam logic [7:0] irq_enable_offset = 8'h4C; // slot chosen for this slice
    localparam logic [7:0] lost_count_offset = 8'h40;
    localparam logic [7:0] serial_port_offset = 8'h48;
    localparam logic [7:0] gp_timer_offset = 8'h58;
    localparam logic [7:0] wake_ctrl_offset = 8'h68;
    localparam logic [7:0] status_offset = 8'h6C; // slice status word, chosen

    // ****************************************
    // field positions
    // ****************************************
    localparam int tx_done_bit = 0;
    localparam int tx_stopped_bit = 1;
    localparam int tx_desc_unavail_bit = 2;
    localparam int abnormal_master_bit = 15;
    localparam int normal_summary_bit = 16;
    localparam int drop_overflow_bit = 16;
    localparam int select_line_bit = 0;
    localparam int serial_clock_bit = 1;
    localparam int serial_in_bit = 2;
    localparam int serial_out_bit = 3;
    localparam int access_select_bit = 11;
    localparam int write_allow_bit = 13;
    localparam int read_allow_bit = 14;
    localparam int continuous_bit = 16;
    localparam int wake_frame_en_bit = 10;
    localparam int link_up_en_bit = 16;
    localparam int link_down_en_bit = 17;
    localparam int pattern_five_bit = 25;
    localparam int pattern_one_bit = 29;
    localparam int crc_seed_bit = 30;
    localparam int link_change_bit = 0;
    localparam int power_event_bit = 1;
    localparam int timer_expired_bit = 2;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [31:0] serial_port_reset = 32'h0000_0007;
    localparam logic [15:0] crc_seed_zero = 16'h0000;
    localparam logic [15:0] crc_seed_ones = 16'hFFFF;

    // ****************************************
    // timing
    // ****************************************
    localparam int clk_period_ns = 10;
    localparam int timer_tick_us = 204;
    localparam int timer_tick_cycles = (timer_tick_us * 1000) / clk_period_ns;

    typedef enum logic [1:0] {
        timer_idle = 2'b00,
        timer_run = 2'b01
    } timer_state_t;
endpackage : csr_slice_pkg

// file: csr_event_if.sv
// bundle of event signals between the register top and its helpers
`timescale 1ns/1ps
interface csr_event_if;
    logic tick;
    logic link_up;
    logic link_change;
    modport source (output tick, output link_change, input link_up);
    modport sink (input tick, input link_change, output link_up);
endinterface : csr_event_if

// file: csr_tick_gen.sv
// prescaler making the 204 us timer tick
`timescale 1ns/1ps
module csr_tick_gen
    import csr_slice_pkg::*;
#(
    parameter int tick_cycles = timer_tick_cycles
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // event bundle
    csr_event_if.source ev
);
    logic [31:0] div_reg;

    // free-running divider, one-cycle tick per period [R13]
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            div_reg <= 32'h0000_0000;
        else if (div_reg == 32'(tick_cycles - 1))
            div_reg <= 32'h0000_0000;
        else
            div_reg <= div_reg + 32'h0000_0001;
    end
    assign ev.tick = (div_reg == 32'(tick_cycles - 1));

    // link edge detect feeding the change flag [R17] [R18]
    logic link_q_reg;
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            link_q_reg <= 1'b0;
        else
            link_q_reg <= ev.link_up;
    end
    assign ev.link_change = link_q_reg ^ ev.link_up;
endmodule : csr_tick_gen

// file: csr_slice_regs.sv
// apb register slice: irq enables, drop counter, eeprom port, timer, wake control
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
module csr_slice_regs
    import csr_slice_pkg::*;
#(
    parameter int tick_cycles = timer_tick_cycles
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic power_on_rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // transmit and receive events
    input wire logic tx_done_evt,
    input wire logic tx_stopped_evt,
    input wire logic tx_desc_unavail_evt,
    input wire logic rx_drop_evt,
    output logic normal_irq,
    output logic abnormal_irq,
    // serial eeprom
    input wire logic eeprom_data_from_rom,
    output logic eeprom_data_to_rom,
    output logic eeprom_clock,
    output logic eeprom_chip_select,
    output logic eeprom_read_en,
    output logic eeprom_write_en,
    // wake logic
    input wire logic link_up,
    input wire logic [4:0] pattern_match,
    output logic [15:0] crc_seed,
    output logic timer_expired,
    output logic power_event_status
);
    // ****************************************
    // helpers
    // ****************************************
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    csr_event_if ev();
    assign ev.link_up = link_up;

    csr_tick_gen #(.tick_cycles(tick_cycles)) u_tick (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .ev(ev)
    );

    // ****************************************
    // apb handshake
    // ****************************************
    // zero-wait slave: pready rises in the access phase
    logic access;
    logic wr_en;
    logic rd_en;
    logic known;
    assign access = psel && penable && pready;
    assign wr_en = access && pwrite;
    assign rd_en = access && !pwrite;
    assign known = hit(paddr, irq_enable_offset) || hit(paddr, lost_count_offset)
        || hit(paddr, serial_port_offset) || hit(paddr, gp_timer_offset)
        || hit(paddr, wake_ctrl_offset) || hit(paddr, status_offset);

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !known;
        end
    end

    // ****************************************
    // interrupt enables
    // ****************************************
    logic [31:0] irq_en_reg;
    // all enables clear at reset [R3]
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            irq_en_reg <= 32'h0000_0000;
        else if (wr_en && hit(paddr, irq_enable_offset))
            irq_en_reg <= pwdata & 32'h0001_8007;
    end

    // summary enables gate each class [R20] [R21]
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            normal_irq <= 1'b0;
            abnormal_irq <= 1'b0;
        end
        else
        begin
            normal_irq <= irq_en_reg[normal_summary_bit]
                && ((tx_done_evt && irq_en_reg[tx_done_bit]) // [R3]
                || (tx_desc_unavail_evt && irq_en_reg[tx_desc_unavail_bit])); // [R1]
            abnormal_irq <= irq_en_reg[abnormal_master_bit]
                && tx_stopped_evt && irq_en_reg[tx_stopped_bit]; // [R2]
        end
    end

    // ****************************************
    // dropped frame counter
    // ****************************************
    logic [15:0] drop_count_reg;
    logic drop_ovf_reg;
    logic drop_read;
    assign drop_read = rd_en && hit(paddr, lost_count_offset);

    // a drop in the read cycle counts as one after the clear; a drop in the setup cycle is counted, then cleared unread
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            drop_count_reg <= 16'h0000;
            drop_ovf_reg <= 1'b0;
        end
        else if (drop_read)
        begin
            drop_count_reg <= {15'h0000, rx_drop_evt}; // [R5]
            drop_ovf_reg <= 1'b0; // [R6]
        end
        else if (rx_drop_evt)
        begin
            drop_count_reg <= drop_count_reg + 16'h0001; // [R4]
            if (drop_count_reg == 16'hFFFF)
                drop_ovf_reg <= 1'b1; // [R6]
        end
    end

    // ****************************************
    // serial eeprom port
    // ****************************************
    logic [31:0] serial_reg;
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            serial_reg <= serial_port_reset;
        else if (wr_en && hit(paddr, serial_port_offset))
            serial_reg <= pwdata & 32'h0000_6807;
    end

    logic rom_selected;
    assign rom_selected = serial_reg[access_select_bit];

    // pins hold idle levels when not selected, avoiding stray clocks [R24]
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            eeprom_data_to_rom <= 1'b0;
            eeprom_clock <= 1'b0;
            eeprom_chip_select <= 1'b0;
            eeprom_read_en <= 1'b0;
            eeprom_write_en <= 1'b0;
        end
        else
        begin
            eeprom_data_to_rom <= rom_selected && serial_reg[serial_in_bit]; // [R10]
            eeprom_clock <= rom_selected && serial_reg[serial_clock_bit]; // [R11]
            eeprom_chip_select <= rom_selected && serial_reg[select_line_bit]; // [R12]
            eeprom_read_en <= rom_selected && serial_reg[read_allow_bit]; // [R7]
            eeprom_write_en <= rom_selected && serial_reg[write_allow_bit]; // [R8]
        end
    end

    // ****************************************
    // general purpose timer
    // ****************************************
    logic [16:0] timer_cfg_reg;
    logic [15:0] timer_count_reg;
    timer_state_t timer_state_reg;
    logic timer_write;
    assign timer_write = wr_en && hit(paddr, gp_timer_offset);

    // load on write; count down per tick; reload only in continuous mode
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            timer_cfg_reg <= 17'h0_0000; // [R14]
            timer_count_reg <= 16'h0000;
            timer_state_reg <= timer_idle;
            timer_expired <= 1'b0;
        end
        else
        begin
            timer_expired <= 1'b0;
            if (timer_write)
            begin
                timer_cfg_reg <= pwdata[16:0];
                timer_count_reg <= pwdata[15:0];
                timer_state_reg <= (pwdata[15:0] != 16'h0000) ? timer_run : timer_idle;
            end
            else
            begin
                case (timer_state_reg)
                    timer_run:
                    begin
                        if (ev.tick)
                        begin
                            if (timer_count_reg == 16'h0001)
                            begin
                                timer_expired <= 1'b1; // [R23]
                                if (timer_cfg_reg[continuous_bit]) // [R14]
                                    timer_count_reg <= timer_cfg_reg[15:0];
                                else
                                begin
                                    timer_count_reg <= 16'h0000;
                                    timer_state_reg <= timer_idle;
                                end
                            end
                            else
                                timer_count_reg <= timer_count_reg - 16'h0001; // [R13]
                        end
                    end
                    default:
                        timer_state_reg <= timer_idle;
                endcase
            end
        end
    end

    // ****************************************
    // wake control and status
    // ****************************************
    logic [31:0] wake_reg;
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            wake_reg <= 32'h0000_0000; // [R16]
        else if (wr_en && hit(paddr, wake_ctrl_offset))
            wake_reg <= pwdata & 32'h7E03_0400;
    end

    // seed follows the type bit [R15]
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            crc_seed <= crc_seed_zero;
        else
            crc_seed <= wake_reg[crc_seed_bit] ? crc_seed_ones : crc_seed_zero;
    end

    logic link_change_reg;
    logic link_set;
    assign link_set = ev.link_change
        && ((link_up && wake_reg[link_up_en_bit]) // [R18]
        || (!link_up && wake_reg[link_down_en_bit])); // [R17]

    // only power-up reset clears; write-one clears, a set wins [R22]
    always_ff @(posedge core_clk or negedge power_on_rst_n)
    begin
        if (!power_on_rst_n)
            link_change_reg <= 1'b0;
        else if (link_set)
            link_change_reg <= 1'b1;
        else if (wr_en && hit(paddr, status_offset) && pwdata[link_change_bit])
            link_change_reg <= 1'b0;
    end

    logic frame_hit;
    assign frame_hit = |(pattern_match & wake_reg[pattern_one_bit:pattern_five_bit]); // [R16]
    always_ff @(posedge core_clk or negedge power_on_rst_n)
    begin
        if (!power_on_rst_n)
            power_event_status <= 1'b0;
        else if (frame_hit && wake_reg[wake_frame_en_bit])
            power_event_status <= 1'b1; // [R19]
        else if (wr_en && hit(paddr, status_offset) && pwdata[power_event_bit])
            power_event_status <= 1'b0;
    end

    // ****************************************
    // read mux
    // ****************************************
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            prdata <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
        begin
            if (hit(paddr, irq_enable_offset))
                prdata <= irq_en_reg;
            else if (hit(paddr, lost_count_offset))
                prdata <= {15'h0000, drop_ovf_reg, drop_count_reg};
            else if (hit(paddr, serial_port_offset))
                prdata <= {serial_reg[31:4], eeprom_data_from_rom, serial_reg[2:0]}; // [R9]
            else if (hit(paddr, gp_timer_offset))
                prdata <= {15'h0000, timer_cfg_reg[continuous_bit], timer_count_reg};
            else if (hit(paddr, wake_ctrl_offset))
                prdata <= wake_reg;
            else if (hit(paddr, status_offset))
                prdata <= {29'h0000_0000, timer_state_reg == timer_run,
                    power_event_status, link_change_reg};
            else
                prdata <= 32'h0000_0000;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    sequence s_drop_read;
        drop_read;
    endsequence
    a_drop_clear_read: assert property (@(posedge core_clk) disable iff (!rst_n) // [R5]
        s_drop_read |=> (drop_count_reg == {15'h0000, $past(rx_drop_evt)}))
        else $error("drop count not cleared by read");
    a_drop_count_up: assert property (@(posedge core_clk) disable iff (!rst_n) // [R4]
        (rx_drop_evt && !drop_read) |=> drop_count_reg == $past(drop_count_reg) + 16'h0001)
        else $error("drop count did not advance");
    a_drop_ovf_set: assert property (@(posedge core_clk) disable iff (!rst_n) // [R6]
        (rx_drop_evt && !drop_read && drop_count_reg == 16'hFFFF) |=> drop_ovf_reg)
        else $error("overflow flag not set");
    a_rom_read_gate: assert property (@(posedge core_clk) disable iff (!rst_n) // [R7]
        eeprom_read_en |-> $past(rom_selected && serial_reg[read_allow_bit]))
        else $error("eeprom read enabled without select");
    a_rom_write_gate: assert property (@(posedge core_clk) disable iff (!rst_n) // [R8]
        eeprom_write_en |-> $past(rom_selected && serial_reg[write_allow_bit]))
        else $error("eeprom write enabled without select");
    a_rom_clock_idle: assert property (@(posedge core_clk) disable iff (!rst_n) // [R24]
        !rom_selected |=> !eeprom_clock && !eeprom_chip_select)
        else $error("eeprom pins active while unselected");
    a_tx_done_irq: assert property (@(posedge core_clk) disable iff (!rst_n) // [R3]
        normal_irq |-> $past(irq_en_reg[normal_summary_bit]))
        else $error("normal interrupt without summary enable");
    a_tx_stop_irq: assert property (@(posedge core_clk) disable iff (!rst_n) // [R2]
        (tx_stopped_evt && irq_en_reg[tx_stopped_bit] && irq_en_reg[abnormal_master_bit])
        |=> abnormal_irq)
        else $error("tx stopped interrupt missing");
    a_link_flag_set: assert property (@(posedge core_clk) disable iff (!power_on_rst_n) // [R18]
        link_set |=> link_change_reg)
        else $error("link change flag not set");
    a_power_event: assert property (@(posedge core_clk) disable iff (!power_on_rst_n) // [R19]
        (frame_hit && wake_reg[wake_frame_en_bit]) |=> power_event_status)
        else $error("power event not raised");
    a_crc_seed_ones: assert property (@(posedge core_clk) disable iff (!rst_n) // [R15]
        wake_reg[crc_seed_bit] |=> crc_seed == crc_seed_ones)
        else $error("crc seed wrong");
endmodule : csr_slice_regs

// file: test_nic_csr_slice_regs.sv
// self-checking testbench of the apb control/status register slice
`timescale 1ns/1ps
module test_nic_csr_slice_regs;
    import csr_slice_pkg::*;
    // ****************************************
    // signals and bookkeeping
    // ****************************************
    localparam int tick = 4; // short prescaler keeps timer runs brief
    logic core_clk = 0, rst_n = 0, power_on_rst_n = 0;
    logic psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata;
    logic pready, pslverr, normal_irq, abnormal_irq;
    logic tx_done_evt = 0, tx_stopped_evt = 0, tx_desc_unavail_evt = 0, rx_drop_evt = 0;
    logic eeprom_data_from_rom = 1, eeprom_data_to_rom, eeprom_clock, eeprom_chip_select;
    logic eeprom_read_en, eeprom_write_en, link_up = 0, timer_expired, power_event_status;
    logic [4:0] pattern_match = 5'b0_0000;
    logic [15:0] crc_seed;
    logic [31:0] rd, v;
    logic err;
    int failures = 0, n_checks = 0, seed = 32'h1243, n, k;

    csr_slice_regs #(.tick_cycles(tick)) dut (.core_clk(core_clk), .rst_n(rst_n),
        .power_on_rst_n(power_on_rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tx_done_evt(tx_done_evt), .tx_stopped_evt(tx_stopped_evt),
        .tx_desc_unavail_evt(tx_desc_unavail_evt), .rx_drop_evt(rx_drop_evt),
        .normal_irq(normal_irq), .abnormal_irq(abnormal_irq),
        .eeprom_data_from_rom(eeprom_data_from_rom), .eeprom_data_to_rom(eeprom_data_to_rom),
        .eeprom_clock(eeprom_clock), .eeprom_chip_select(eeprom_chip_select),
        .eeprom_read_en(eeprom_read_en), .eeprom_write_en(eeprom_write_en), .link_up(link_up),
        .pattern_match(pattern_match), .crc_seed(crc_seed), .timer_expired(timer_expired),
        .power_event_status(power_event_status));

    // 100 MHz core clock
    initial
    begin
        forever #5 core_clk = ~core_clk;
    end

    // ****************************************
    // helpers
    // ****************************************
    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask : chk

    // one apb transfer; entered just after a rising edge, leaves one idle edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask : apb

    // interrupt lines expected from enables and events
    function automatic logic [1:0] irq_exp(input logic [31:0] en, input logic [2:0] e);
        irq_exp[0] = en[16] & ((e[0] & en[0]) | (e[2] & en[2]));
        irq_exp[1] = en[15] & e[1] & en[1];
    endfunction : irq_exp

    task wait_exp();
        n = 0;
        do begin @(posedge core_clk); n++; end while (timer_expired !== 1'b1 && n < 200);
    endtask : wait_exp

    // closing report and verdict
    task test_done();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : test_done

    // watchdog sized well above the overflow run of 65537 cycles
    initial
    begin
        #900_000;
        failures++;
        test_done();
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        power_on_rst_n <= 1'b1;
        @(posedge core_clk);
        // reset values and unmapped access
        apb(0, serial_port_offset, 0); chk(rd, 32'h0000_000F, "serial reset");
        apb(0, irq_enable_offset, 0); chk(rd, 0, "irq enable reset");
        apb(0, wake_ctrl_offset, 0); chk(rd, 0, "wake reset");
        apb(0, gp_timer_offset, 0); chk(rd, 0, "timer reset");
        apb(0, 8'h44, 0); chk(rd, 0, "unmapped read data");
        chk(32'(err), 1, "unmapped read error");
        $display("test reset done");
        // interrupt gating over random enables and events
        repeat (24)
        begin
            v = $random(seed) & 32'h0001_8007;
            k = $random(seed) & 7;
            apb(1, irq_enable_offset, v);
            apb(0, irq_enable_offset, 0); chk(rd, v, "irq enable readback");
            {tx_desc_unavail_evt, tx_stopped_evt, tx_done_evt} <= k[2:0];
            @(posedge core_clk);
            {tx_desc_unavail_evt, tx_stopped_evt, tx_done_evt} <= 3'b000;
            @(posedge core_clk);
            chk({abnormal_irq, normal_irq}, irq_exp(v, k[2:0]), "irq");
        end
        $display("test irq done");
        // dropped frame counter, clear on read, overflow
        k = ($random(seed) & 7) + 1;
        repeat (k)
        begin
            rx_drop_evt <= 1'b1;
            @(posedge core_clk);
            rx_drop_evt <= 1'b0;
            @(posedge core_clk);
        end
        apb(0, lost_count_offset, 0); chk(rd, k, "drop count");
        apb(0, lost_count_offset, 0); chk(rd, 0, "drop count cleared");
        rx_drop_evt <= 1'b1;
        repeat (65537) @(posedge core_clk);
        rx_drop_evt <= 1'b0;
        @(posedge core_clk);
        apb(0, lost_count_offset, 0); chk(rd, 32'h0001_0001, "drop overflow");
        apb(0, lost_count_offset, 0); chk(rd, 0, "overflow cleared");
        $display("test drop counter done");
        // eeprom port: pins gated by select bit, live data bit
        repeat (16)
        begin
            v = $random(seed) & 32'h0000_6807;
            n = $random(seed);
            eeprom_data_from_rom <= n[0];
            apb(1, serial_port_offset, v);
            apb(0, serial_port_offset, 0);
            chk(rd, v | (32'(n[0]) << 3), "serial readback");
            chk({eeprom_read_en, eeprom_write_en}, {2{v[11]}} & {v[14], v[13]},
                "rom en");
            chk({eeprom_data_to_rom, eeprom_clock, eeprom_chip_select}, {3{v[11]}} & v[2:0],
                "rom pins");
        end
        $display("test eeprom done");
        // one-shot then continuous timer
        apb(1, gp_timer_offset, 32'h0000_0003);
        wait_exp(); chk(32'(n <= 4 * tick + 4 && n >= 2 * tick), 1, "one-shot period");
        wait_exp(); chk(32'(n), 200, "one-shot stops");
        apb(0, status_offset, 0); chk(rd & 4, 0, "timer stopped");
        apb(1, gp_timer_offset, 32'h0001_0002);
        wait_exp(); chk(32'(n <= 3 * tick + 4), 1, "first expiry");
        wait_exp(); chk(32'(n <= 2 * tick + 2 && n >= tick), 1, "reload");
        apb(0, gp_timer_offset, 0); chk(rd[16], 1, "continuous bit");
        apb(1, gp_timer_offset, 0);
        $display("test timer done");
        // wake control: writable mask and crc seed
        apb(1, wake_ctrl_offset, 32'hFFFF_FFFF);
        apb(0, wake_ctrl_offset, 0); chk(rd, 32'h7E03_0400, "wake mask");
        chk(crc_seed, crc_seed_ones, "seed ones");
        apb(1, wake_ctrl_offset, 0);
        // seed register follows the write one edge later
        @(posedge core_clk);
        chk(crc_seed, crc_seed_zero, "seed zero");
        // pattern enables decide whether a match is a wake event
        for (int i = 0; i < 5; i++)
        begin
            apb(1, wake_ctrl_offset, (32'h1 << (29 - i)) | 32'h0000_0400);
            for (int j = 0; j < 2; j++)
            begin
                apb(1, status_offset, 32'h0000_0002);
                pattern_match <= 5'(1 << ((4 - i + j) % 5));
                @(posedge core_clk);
                pattern_match <= 5'b0_0000;
                repeat (2) @(posedge core_clk);
                apb(0, status_offset, 0);
                chk(rd & 2, (j == 0) ? 2 : 0, "wake match");
                chk(power_event_status, (j == 0) ? 1 : 0, "power event pin");
            end
        end
        apb(1, status_offset, 32'h0000_0002);
        // link changes under each detect enable
        for (int i = 0; i < 3; i++)
        begin
            apb(1, wake_ctrl_offset, (i == 2) ? 0 : (32'h1_0000 << i));
            apb(1, status_offset, 32'h0000_0001);
            link_up <= ~link_up;
            repeat (3) @(posedge core_clk);
            apb(0, status_offset, 0); chk(rd & 1, (i < 2) ? 1 : 0, "link change");
        end
        apb(1, wake_ctrl_offset, 32'h0002_0000);
        link_up <= 1'b0; // falling link under the down enable sets the flag
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b0;
        @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        apb(0, status_offset, 0); chk(rd & 1, 1, "flag survives reset");
        apb(1, status_offset, 32'h0000_0001);
        apb(0, status_offset, 0); chk(rd & 1, 0, "flag write-one clear");
        $display("test wake done");
        test_done();
    end
endmodule : test_nic_csr_slice_regs
